// file: verilog/cbi_cpu_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "cbi_defines.svh"
module cbi_cpu_end
   import cbi_pkg::*;
#(
   parameter int ADDR_W = 24
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   cbi_link_if.dev link,
   input wire logic req_valid_in,
   input wire logic req_write_in,
   input wire logic [ADDR_W-1:0] req_addr_in,
   input wire cbi_width_e req_width_in,
   input wire logic [31:0] req_wdata_in,
   output logic req_busy_out,
   output logic req_done_out,
   output logic [31:0] req_rdata_out,
   input wire logic instr_start_in,
   input wire logic [23:0] instr_addr_in,
   input wire logic instr_end_in,
   input wire logic [23:0] next_addr_in,
   input wire logic rmw_start_in,
   input wire logic legacy8_in,
   input wire logic legacy16_in,
   input wire cbi_width_e acc_width_in,
   input wire logic index_width_in,
   input wire logic irq_disable_in,
   input wire logic halt_op_in,
   input wire logic [31:0] index_x_in,
   input wire logic [31:0] index_y_in,
   output logic [31:0] index_x_out,
   output logic [31:0] index_y_out,
   output logic int_start_out,
   output logic [23:0] int_vector_out,
   output logic [23:0] int_return_out,
   output logic halted_out,
   output logic wake_out,
   output logic reg_write_inhibit_out
);
   if (ADDR_W != 24) begin : g_chk
      $error("cbi_cpu_end: ADDR_W must be 24");
   end

   cbi_bus_e state_q, state_d;
   logic [23:0] addr_q, addr_d;
   logic [1:0] idx_q, idx_d, last_q, last_d;
   logic wr_q, wr_d;
   logic [31:0] wdat_q, wdat_d;
   logic [31:0] rdat_q;
   logic done_q;
   logic [3:0] lock_q, lock_d;
   logic emu;
   cbi_width_e rmw_w;
   logic cancel_q, irq_low_q, halted_q;
   logic [23:0] opaddr_q;
   logic take_cancel, take_irq;
   logic int_q, wake_q;
   logic [23:0] vec_q, ret_q;
   logic [15:0] a_lo_q;
   logic a_oe_q, rw_q, rw_oe_q, d_oe_q, ph_q, lock_n_q;
   logic [7:0] d_q;
   logic [1:0] emu_q;
   logic [31:0] x_q, y_q;

   assign emu = legacy8_in | legacy16_in;
   assign rmw_w = legacy8_in ? WID_8 : acc_width_in;

   // Bus engine next state
   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      idx_d = idx_q;
      last_d = last_q;
      wr_d = wr_q;
      wdat_d = wdat_q;
      unique case (state_q)
         BUS_IDLE: begin
            if (req_valid_in && link.ready) begin
               state_d = BUS_ADDR;
               addr_d = req_addr_in;
               idx_d = 2'h0;
               wr_d = req_write_in;
               wdat_d = req_wdata_in;
               // Last byte index per operand width [RULE_09]
               last_d = (req_width_in == WID_32) ? 2'h3 :
                        (req_width_in == WID_16) ? 2'h1 : 2'h0;
            end
         end
         BUS_ADDR: begin
            if (link.ready) begin // [RULE_18]
               state_d = BUS_DATA1;
            end
         end
         BUS_DATA1: state_d = BUS_DATA2;
         BUS_DATA2: begin
            if (idx_q == last_q) begin
               state_d = BUS_IDLE;
            end else begin
               state_d = BUS_ADDR; // [RULE_09]
               addr_d = addr_q + 24'h1;
               idx_d = idx_q + 2'h1;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         state_q <= BUS_IDLE;
         addr_q <= 24'h0;
         idx_q <= 2'h0;
         last_q <= 2'h0;
         wr_q <= 1'b0;
         wdat_q <= 32'h0;
      end else begin
         state_q <= state_d;
         addr_q <= addr_d;
         idx_q <= idx_d;
         last_q <= last_d;
         wr_q <= wr_d;
         wdat_q <= wdat_d;
      end
   end

   // Read capture and completion
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         rdat_q <= 32'h0;
         done_q <= 1'b0;
      end else begin
         done_q <= (state_q == BUS_DATA2) && (idx_q == last_q);
         if (state_q == BUS_IDLE && state_d == BUS_ADDR) begin
            rdat_q <= 32'h0;
         end else if (state_q == BUS_DATA2 && !wr_q) begin
            rdat_q[{idx_q, 3'b000} +: 8] <= link.dat_bus; // [RULE_08]
         end
      end
   end

   // Link pins, registered from next state, bus enable and legacy flags
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         a_lo_q <= 16'h0;
         a_oe_q <= 1'b0;
         rw_q <= 1'b1;
         rw_oe_q <= 1'b0;
         d_q <= 8'h0;
         d_oe_q <= 1'b0;
         ph_q <= 1'b0;
         emu_q <= 2'h3;
      end else begin
         a_lo_q <= addr_d[15:0]; // [RULE_05]
         a_oe_q <= link.bus_drive_enable; // [RULE_05] [RULE_06]
         rw_q <= !(wr_d && state_d != BUS_IDLE);
         rw_oe_q <= link.bus_drive_enable; // [RULE_06]
         d_q <= (state_d == BUS_ADDR) ? addr_d[23:16] : wdat_d[{idx_d, 3'b000} +: 8]; // [RULE_08]
         d_oe_q <= link.bus_drive_enable && ((state_d == BUS_ADDR) ||
                   (wr_d && (state_d == BUS_DATA1 || state_d == BUS_DATA2))); // [RULE_07]
         ph_q <= (state_d == BUS_DATA1) || (state_d == BUS_DATA2);
         emu_q <= {legacy16_in, legacy8_in}; // [RULE_10]
      end
   end

   // Lock counter over the tail of a read-modify-write
   always_comb begin
      lock_d = lock_q;
      if (rmw_start_in) begin
         lock_d = (rmw_w == WID_32) ? `CBI_RMW_CYC_32 :
                  (rmw_w == WID_16) ? `CBI_RMW_CYC_16 : `CBI_RMW_CYC_8; // [RULE_15]
      end else if (lock_q != 4'h0 && state_q == BUS_DATA2) begin
         lock_d = lock_q - 4'h1;
      end else if (lock_q != 4'h0 && state_q == BUS_IDLE && !req_valid_in) begin
         lock_d = lock_q - 4'h1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         lock_q <= 4'h0;
         lock_n_q <= 1'b1;
      end else begin
         lock_q <= lock_d;
         lock_n_q <= (lock_d == 4'h0); // [RULE_15]
      end
   end

   // Interrupt recognition
   assign take_cancel = cancel_q && (instr_end_in || halted_q); // [RULE_01]
   assign take_irq = !take_cancel && irq_low_q && !irq_disable_in &&
                     (instr_end_in || halted_q); // [RULE_11] [RULE_13] [RULE_14]

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         cancel_q <= 1'b0;
      end else if (!link.cancel_request_n) begin
         cancel_q <= 1'b1; // [RULE_04] [RULE_19]
      end else if (take_cancel) begin
         cancel_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         irq_low_q <= 1'b0;
         opaddr_q <= 24'h0;
      end else begin
         irq_low_q <= !link.maskable_interrupt_n; // [RULE_19]
         if (instr_start_in) begin
            opaddr_q <= instr_addr_in;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         halted_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         wake_q <= halted_q && irq_low_q && irq_disable_in && !cancel_q;
         if (halt_op_in) begin
            halted_q <= 1'b1;
         end else if (halted_q && (irq_low_q || cancel_q)) begin
            halted_q <= 1'b0; // [RULE_13]
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         int_q <= 1'b0;
         vec_q <= 24'h0;
         ret_q <= 24'h0;
      end else begin
         int_q <= take_cancel || take_irq;
         if (take_cancel) begin
            vec_q <= emu ? `CBI_VEC_CANCEL_EMU : `CBI_VEC_CANCEL_NAT; // [RULE_03]
            ret_q <= opaddr_q; // [RULE_02]
         end else if (take_irq) begin
            vec_q <= emu ? `CBI_VEC_IRQ_EMU : `CBI_VEC_IRQ_NAT; // [RULE_12]
            ret_q <= next_addr_in;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         x_q <= 32'h0;
         y_q <= 32'h0;
      end else begin
         x_q <= index_width_in ? {24'h0, index_x_in[7:0]} : index_x_in; // [RULE_17]
         y_q <= index_width_in ? {24'h0, index_y_in[7:0]} : index_y_in; // [RULE_17]
      end
   end

   assign link.addr_lo = a_lo_q;
   assign link.addr_lo_oe = a_oe_q;
   assign link.rw_n = rw_q;
   assign link.rw_n_oe = rw_oe_q;
   assign link.dat_dev = d_q;
   assign link.dat_dev_oe = d_oe_q;
   assign link.phase_two_clock = ph_q;
   assign link.emulation_state = emu_q;
   assign link.lock_hold_n = lock_n_q;
   assign req_busy_out = (state_q != BUS_IDLE);
   assign req_done_out = done_q;
   assign req_rdata_out = rdat_q;
   assign index_x_out = x_q;
   assign index_y_out = y_q;
   assign int_start_out = int_q;
   assign int_vector_out = vec_q;
   assign int_return_out = ret_q;
   assign halted_out = halted_q;
   assign wake_out = wake_q;
   assign reg_write_inhibit_out = cancel_q; // [RULE_01]
endmodule // cbi_cpu_end
`default_nettype wire

// file: verilog/cbi_defines.svh
`ifndef CBI_DEFINES_SVH
`define CBI_DEFINES_SVH
// Function
// [RULE_01] Cancel request freezes register writes of instruction
// [RULE_02] Cancel return address is the cancelled opcode
// [RULE_03] Cancel vector 00FFF8 emulation, 00FFE8 native
// [RULE_04] Cancel low in any clock registers request
// [RULE_05] Low sixteen address bits on dedicated outputs
// [RULE_06] Bus enable low floats address and direction
// [RULE_07] Shared lines driven first half, writes second
// [RULE_08] Upper address first half, data second half
// [RULE_09] Wide operands move as consecutive byte cycles
// [RULE_10] Emulation output mirrors both legacy mode flags
// [RULE_11] Low maskable request interrupts after instruction
// [RULE_12] Maskable vector 00FFFE emulation, 00FFEE native
// [RULE_13] After halt op, pending request taken immediately
// [RULE_14] Maskable request level sensitive, never latched
// [RULE_15] Lock low final three, five, nine cycles
// [RULE_16] Arbiter defers grant while lock is low
// [RULE_17] Narrow index mode zeroes upper index bytes
// [RULE_18] Ready low holds the bus engine still; code waits only in idle and address states
// [RULE_19] Requests sampled on clock, cancel held latched

`define CBI_VEC_CANCEL_EMU 24'h00fff8
`define CBI_VEC_CANCEL_NAT 24'h00ffe8
`define CBI_VEC_IRQ_EMU 24'h00fffe
`define CBI_VEC_IRQ_NAT 24'h00ffee

`define CBI_RMW_CYC_8 4'h3
`define CBI_RMW_CYC_16 4'h5
`define CBI_RMW_CYC_32 4'h9

`define CBI_REG_CTRL 12'h000
`define CBI_REG_STAT 12'h004
`define CBI_REG_INT_STAT 12'h008
`define CBI_REG_INT_CLR 12'h00c
`define CBI_REG_INT_EN 12'h010
`define CBI_REG_MEM_BASE 12'h100

`define CBI_CTRL_CANCEL 0
`define CBI_CTRL_IRQ 1
`define CBI_CTRL_BUSREQ 2
`define CBI_CTRL_STALL 3
`define CBI_CTRL_RST 4'h0

`define CBI_EV_WRITE 0
`define CBI_EV_LOCK 1
`define CBI_EV_GRANT 2
`define CBI_INT_RST 3'h0
`endif

// file: verilog/cbi_pkg.sv
package cbi_pkg;
   typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_DATA1, BUS_DATA2} cbi_bus_e;
   typedef enum logic [1:0] {WID_8, WID_16, WID_32} cbi_width_e;
   typedef logic [7:0] cbi_byte_t;
endpackage

// file: verilog/cbi_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cbi_link_if;
   logic [15:0] addr_lo;
   logic addr_lo_oe;
   logic rw_n;
   logic rw_n_oe;
   logic [7:0] dat_dev;
   logic dat_dev_oe;
   logic [7:0] dat_host;
   logic dat_host_oe;
   logic [7:0] dat_bus;
   logic bus_drive_enable;
   logic phase_two_clock;
   logic [1:0] emulation_state;
   logic cancel_request_n;
   logic maskable_interrupt_n;
   logic lock_hold_n;
   logic ready;

   // Shared lines resolve with a pull-up when nobody drives
   assign dat_bus = dat_dev_oe ? dat_dev : (dat_host_oe ? dat_host : 8'hff);

   modport dev (
      output addr_lo, addr_lo_oe, rw_n, rw_n_oe, dat_dev, dat_dev_oe,
      output phase_two_clock, emulation_state, lock_hold_n,
      input dat_bus, dat_host_oe, bus_drive_enable, cancel_request_n,
      input maskable_interrupt_n, ready
   );
   modport host (
      input addr_lo, addr_lo_oe, rw_n, rw_n_oe, dat_dev, dat_dev_oe,
      input phase_two_clock, emulation_state, lock_hold_n, dat_bus,
      output dat_host, dat_host_oe, bus_drive_enable, cancel_request_n,
      output maskable_interrupt_n, ready
   );
endinterface
`default_nettype wire

// file: verilog/cbi_sys_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "cbi_defines.svh"
module cbi_sys_end
   import cbi_pkg::*;
#(
   parameter int MEM_DEPTH = 16
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   cbi_link_if.host link,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic irq_out
);
   localparam int MW = $clog2(MEM_DEPTH);
   if (MEM_DEPTH < 2 || MEM_DEPTH > 64 || (1 << MW) != MEM_DEPTH) begin : g_chk
      $error("cbi_sys_end: MEM_DEPTH must be a power of two, 2..64");
   end

   cbi_byte_t mem [MEM_DEPTH];
   logic [3:0] ctrl_q;
   logic [2:0] ist_q, ien_q, ev;
   logic [7:0] hi_q, dh_q;
   logic dh_oe_q, ph_prev_q, lock_prev_q, grant_q, cancel_n_q, irq_n_q, rdy_q, ben_q;
   logic pready_q, perr_q, irq_q, wr_ev, apb_wr, mem_sel;
   logic [31:0] prdata_q, rd_v;
   logic rd_err;
   logic [MW-1:0] cpu_idx, apb_idx;

   assign cpu_idx = link.addr_lo[MW-1:0];
   assign apb_idx = paddr_in[MW+1:2];
   assign mem_sel = (paddr_in[11:8] == 4'(`CBI_REG_MEM_BASE >> 8));
   assign apb_wr = psel_in && penable_in && pready_q && pwrite_in;
   assign wr_ev = link.phase_two_clock && ph_prev_q && !link.rw_n && link.dat_dev_oe;
   assign ev = {!grant_q && ctrl_q[`CBI_CTRL_BUSREQ] && link.lock_hold_n,
                lock_prev_q && !link.lock_hold_n, wr_ev};

   // Read mux and decode
   always_comb begin
      rd_v = 32'h0;
      rd_err = 1'b0;
      if (mem_sel) begin
         rd_v = {24'h0, mem[apb_idx]};
      end else begin
         unique case (paddr_in)
            `CBI_REG_CTRL: rd_v = {28'h0, ctrl_q};
            `CBI_REG_STAT: rd_v = {20'h0, hi_q, link.emulation_state, !link.lock_hold_n, grant_q};
            `CBI_REG_INT_STAT: rd_v = {29'h0, ist_q};
            `CBI_REG_INT_EN: rd_v = {29'h0, ien_q};
            `CBI_REG_INT_CLR: rd_v = 32'h0;
            default: rd_err = 1'b1;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         pready_q <= 1'b0;
         perr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= psel_in && penable_in && !pready_q;
         perr_q <= psel_in && penable_in && !pready_q && rd_err;
         if (psel_in && penable_in && !pready_q && !pwrite_in) begin
            prdata_q <= rd_v;
         end
      end
   end

   // Control, cancel pulse and interrupt registers
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         ctrl_q <= `CBI_CTRL_RST;
         ien_q <= `CBI_INT_RST;
         ist_q <= `CBI_INT_RST;
         irq_q <= 1'b0;
      end else begin
         ctrl_q[`CBI_CTRL_CANCEL] <= 1'b0;
         if (apb_wr && paddr_in == `CBI_REG_CTRL) begin
            ctrl_q <= pwdata_in[3:0];
         end
         if (apb_wr && paddr_in == `CBI_REG_INT_EN) begin
            ien_q <= pwdata_in[2:0];
         end
         if (apb_wr && paddr_in == `CBI_REG_INT_CLR) begin
            ist_q <= (ist_q & ~pwdata_in[2:0]) | ev;
         end else begin
            ist_q <= ist_q | ev;
         end
         irq_q <= |((ist_q | ev) & ien_q);
      end
   end

   // Link drive and arbitration
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         grant_q <= 1'b0;
         ben_q <= 1'b1;
         cancel_n_q <= 1'b1;
         irq_n_q <= 1'b1;
         rdy_q <= 1'b1;
         ph_prev_q <= 1'b0;
         lock_prev_q <= 1'b1;
         hi_q <= 8'h0;
         dh_q <= 8'h0;
         dh_oe_q <= 1'b0;
      end else begin
         if (!ctrl_q[`CBI_CTRL_BUSREQ]) begin
            grant_q <= 1'b0;
            ben_q <= 1'b1;
         end else if (link.lock_hold_n) begin
            grant_q <= 1'b1; // [RULE_16]
            ben_q <= 1'b0; // [RULE_16]
         end
         cancel_n_q <= !ctrl_q[`CBI_CTRL_CANCEL]; // [RULE_04]
         irq_n_q <= !ctrl_q[`CBI_CTRL_IRQ]; // [RULE_14]
         rdy_q <= !ctrl_q[`CBI_CTRL_STALL]; // [RULE_18]
         ph_prev_q <= link.phase_two_clock;
         lock_prev_q <= link.lock_hold_n;
         if (!link.phase_two_clock && link.dat_dev_oe) begin
            hi_q <= link.dat_bus; // [RULE_08]
         end
         dh_oe_q <= link.phase_two_clock && !ph_prev_q && link.rw_n && !grant_q;
         dh_q <= mem[cpu_idx];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (wr_ev) begin
         mem[cpu_idx] <= link.dat_bus;
      end else if (apb_wr && mem_sel) begin
         mem[apb_idx] <= pwdata_in[7:0];
      end
   end

   assign link.bus_drive_enable = ben_q;
   assign link.cancel_request_n = cancel_n_q;
   assign link.maskable_interrupt_n = irq_n_q;
   assign link.ready = rdy_q;
   assign link.dat_host = dh_q;
   assign link.dat_host_oe = dh_oe_q;
   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = perr_q;
   assign irq_out = irq_q;
endmodule // cbi_sys_end
`default_nettype wire

// file: sim/cbi_link_chk.sv
`timescale 1ns/10ps
`default_nettype none
module cbi_link_chk (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic [15:0] addr_lo,
   input wire logic addr_lo_oe,
   input wire logic rw_n,
   input wire logic rw_n_oe,
   input wire logic dat_dev_oe,
   input wire logic dat_host_oe,
   input wire logic bus_drive_enable,
   input wire logic phase_two_clock,
   input wire logic lock_hold_n,
   input wire logic ready
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (sys_rst_in);
   property p_float;
      !bus_drive_enable |=> !addr_lo_oe && !rw_n_oe && !dat_dev_oe;
   endproperty
   a_float: assert property (p_float)
      else $error("link outputs driven while bus enable low");
   property p_oe_pair;
      rw_n_oe == addr_lo_oe;
   endproperty
   a_oe_pair: assert property (p_oe_pair)
      else $error("direction and address enables differ");
   property p_data;
      addr_lo_oe && phase_two_clock |-> dat_dev_oe == !rw_n;
   endproperty
   a_data: assert property (p_data)
      else $error("shared lines wrong in data half");
   property p_host;
      dat_host_oe |-> phase_two_clock && rw_n && !dat_dev_oe;
   endproperty
   a_host: assert property (p_host)
      else $error("far side drives outside read data half");
   property p_phase;
      $rose(phase_two_clock) |=> phase_two_clock ##1 !phase_two_clock;
   endproperty
   a_phase: assert property (p_phase)
      else $error("data half not two clocks");
   property p_lock;
      $fell(lock_hold_n) |-> !lock_hold_n [*3] ##[1:60] lock_hold_n;
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock low length out of range");
   property p_grant;
      $fell(bus_drive_enable) |-> $past(lock_hold_n);
   endproperty
   a_grant: assert property (p_grant)
      else $error("bus granted while locked");
   property p_ready;
      !ready && addr_lo_oe && !phase_two_clock |=> !phase_two_clock && $stable(addr_lo);
   endproperty
   a_ready: assert property (p_ready)
      else $error("bus moved while not ready");
endmodule // cbi_link_chk
`default_nettype wire

// file: sim/cpu_bus_and_interrupt_pins_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "cbi_defines.svh"
module cpu_bus_and_interrupt_pins_tb
   import cbi_pkg::*;
;
   logic core_clk_in;
   logic sys_rst_in = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, irq, e, got;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q, req_wdata = 32'h0, req_rdata;
   logic [31:0] idx_x = 32'h0, idx_y = 32'h0, idx_xo, idx_yo;
   logic req_valid = 1'h0, req_write = 1'h0, req_busy, req_done;
   logic [23:0] req_addr = 24'h0, instr_addr = 24'h0, next_addr = 24'h0, int_vec, int_ret;
   cbi_width_e req_width = WID_8, acc_width = WID_8;
   logic [3:0] pls = 4'h0;
   logic legacy8 = 1'h0, legacy16 = 1'h0, index_width = 1'h0, irq_dis = 1'h0, ph_q = 1'h0;
   logic int_start, halted, wake, inhibit;
   logic [15:0] first_addr;
   int n_fail = 0, samples_checked = 0, cyc = 0, n_cyc = 0;
   cbi_link_if link_i ();
   cbi_cpu_end cbi_cpu_end_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .link(link_i.dev), .req_valid_in(req_valid), .req_write_in(req_write),
      .req_addr_in(req_addr), .req_width_in(req_width), .req_wdata_in(req_wdata),
      .req_busy_out(req_busy), .req_done_out(req_done), .req_rdata_out(req_rdata),
      .instr_start_in(pls[0]), .instr_addr_in(instr_addr), .instr_end_in(pls[1]),
      .next_addr_in(next_addr), .rmw_start_in(pls[2]), .legacy8_in(legacy8),
      .legacy16_in(legacy16), .acc_width_in(acc_width), .index_width_in(index_width),
      .irq_disable_in(irq_dis), .halt_op_in(pls[3]), .index_x_in(idx_x), .index_y_in(idx_y),
      .index_x_out(idx_xo), .index_y_out(idx_yo), .int_start_out(int_start),
      .int_vector_out(int_vec), .int_return_out(int_ret), .halted_out(halted),
      .wake_out(wake), .reg_write_inhibit_out(inhibit));
   cbi_sys_end cbi_sys_end_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .link(link_i.host), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .irq_out(irq));
   cbi_link_chk cbi_link_chk_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .addr_lo(link_i.addr_lo), .addr_lo_oe(link_i.addr_lo_oe), .rw_n(link_i.rw_n),
      .rw_n_oe(link_i.rw_n_oe), .dat_dev_oe(link_i.dat_dev_oe),
      .dat_host_oe(link_i.dat_host_oe), .bus_drive_enable(link_i.bus_drive_enable),
      .phase_two_clock(link_i.phase_two_clock), .lock_hold_n(link_i.lock_hold_n),
      .ready(link_i.ready));
   initial begin
      core_clk_in = 1'h0;
      forever #10 core_clk_in = ~core_clk_in;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Timeout and bus cycle monitor
   always @(posedge core_clk_in) begin
      cyc <= cyc + 1;
      ph_q <= link_i.phase_two_clock;
      if (link_i.phase_two_clock && !ph_q) n_cyc++;
      if (link_i.dat_dev_oe && !link_i.phase_two_clock && n_cyc == 0) first_addr <= link_i.addr_lo;
      if (cyc == 20000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_in);
      penable <= 1'h1;
      do @(posedge core_clk_in); while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic pulse(input int k);
      @(posedge core_clk_in);
      pls <= 4'h1 << k;
      @(posedge core_clk_in);
      pls <= 4'h0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   task automatic wait_int();
      got = 1'h0;
      repeat (4) begin
         #1;
         if (int_start === 1'h1) got = 1'h1;
         @(posedge core_clk_in);
      end
   endtask
   task automatic bus_req(input logic w, input logic [23:0] a, input cbi_width_e wd,
      input logic [31:0] d, input int nb);
      @(posedge core_clk_in);
      n_cyc = 0;
      req_valid <= 1'h1;
      req_write <= w;
      req_addr <= a;
      req_width <= wd;
      req_wdata <= d;
      do @(posedge core_clk_in); while (req_busy !== 1'h1);
      req_valid <= 1'h0;
      do settle(1); while (req_done !== 1'h1);
      q = req_rdata;
      chk(n_cyc, nb);
      chk(first_addr, a[15:0]);
   endtask
   task automatic t_bus();
      #1;
      chk(link_i.emulation_state, 2'h3);
      apb(1'h0, 12'h040, 32'h0);
      chk(e, 1'h1);
      bus_req(1'h1, 24'h5a0004, WID_32, 32'h44332211, 4);
      apb(1'h0, 12'h004, 32'h0);
      chk(q[11:4], 8'h5a);
      for (int i = 0; i < 4; i++) begin
         apb(1'h0, 12'h110 + 12'(4 * i), 32'h0);
         chk(q[7:0], 8'(8'h11 * (i + 1)));
      end
      bus_req(1'h0, 24'h000006, WID_16, 32'h0, 2);
      chk(q[15:0], 16'h4433);
      chk(irq, 1'h0);
      wr(12'h010, 32'h1);
      settle(2);
      chk(irq, 1'h1);
      wr(12'h00c, 32'h1);
      settle(2);
      chk(irq, 1'h0);
   endtask
   task automatic t_stall_grant();
      wr(12'h000, 32'h8);
      @(posedge core_clk_in);
      req_valid <= 1'h1;
      req_write <= 1'h0;
      req_addr <= 24'h000004;
      req_width <= WID_8;
      repeat (6) @(posedge core_clk_in);
      chk(req_busy, 1'h0);
      req_valid <= 1'h0;
      wr(12'h000, 32'h0);
      bus_req(1'h0, 24'h000004, WID_8, 32'h0, 1);
      chk(q[7:0], 8'h11);
      wr(12'h000, 32'h4);
      settle(3);
      chk(link_i.addr_lo_oe, 1'h0);
      wr(12'h000, 32'h0);
      settle(3);
      chk(link_i.addr_lo_oe, 1'h1);
   endtask
   task automatic t_lock();
      int n;
      int ex[4] = '{3, 5, 9, 3};
      cbi_width_e wl[4] = '{WID_8, WID_16, WID_32, WID_32};
      for (int i = 0; i < 4; i++) begin
         acc_width <= wl[i];
         legacy8 <= (i == 3);
         pulse(2);
         n = 0;
         #1;
         repeat (20) begin
            if (link_i.lock_hold_n === 1'h0) n++;
            settle(1);
         end
         chk(n, ex[i]);
      end
      legacy8 <= 1'h0;
      pulse(2);
      wr(12'h000, 32'h4);
      settle(2);
      chk(link_i.bus_drive_enable, 1'h1);
      settle(10);
      chk(link_i.bus_drive_enable, 1'h0);
      wr(12'h000, 32'h0);
      settle(3);
   endtask
   task automatic t_emu_index();
      for (int i = 0; i < 4; i++) begin
         legacy8 <= i[0];
         legacy16 <= i[1];
         settle(2);
         chk(link_i.emulation_state, i[1:0]);
      end
      legacy8 <= 1'h0;
      legacy16 <= 1'h0;
      index_width <= 1'h1;
      idx_x <= 32'hdeadbeef;
      idx_y <= 32'h12345678;
      settle(2);
      chk(idx_xo, 32'h000000ef);
      chk(idx_yo, 32'h00000078);
   endtask
   task automatic irq_try(input logic l8, input logic dis, input logic [31:0] c,
      input logic ex, input logic [23:0] vec);
      legacy8 <= l8;
      irq_dis <= dis;
      next_addr <= 24'h123456;
      wr(12'h000, c);
      settle(2);
      pulse(1);
      wait_int();
      chk(got, ex);
      if (ex) chk(int_vec, vec);
      if (ex) chk(int_ret, 24'h123456);
   endtask
   task automatic t_int();
      irq_try(1'h0, 1'h0, 32'h2, 1'h1, `CBI_VEC_IRQ_NAT);
      irq_try(1'h1, 1'h0, 32'h2, 1'h1, `CBI_VEC_IRQ_EMU);
      irq_try(1'h0, 1'h1, 32'h2, 1'h0, 24'h0);
      irq_try(1'h0, 1'h0, 32'h0, 1'h0, 24'h0);
      for (int m = 0; m < 2; m++) begin
         legacy16 <= m[0];
         instr_addr <= 24'h00abcd;
         pulse(0);
         wr(12'h000, 32'h1);
         settle(2);
         chk(inhibit, 1'h1);
         pulse(1);
         wait_int();
         chk(got, 1'h1);
         chk(int_vec, m ? `CBI_VEC_CANCEL_EMU : `CBI_VEC_CANCEL_NAT);
         chk(int_ret, 24'h00abcd);
         chk(inhibit, 1'h0);
      end
      legacy16 <= 1'h0;
      pulse(3);
      settle(2);
      chk(halted, 1'h1);
      wr(12'h000, 32'h2);
      wait_int();
      chk(got, 1'h1);
      wr(12'h000, 32'h0);
      irq_dis <= 1'h1;
      pulse(3);
      wr(12'h000, 32'h2);
      settle(3);
      chk(wake, 1'h1);
      chk(int_start, 1'h0);
      chk(halted, 1'h0);
   endtask
   initial begin
      repeat (10) @(posedge core_clk_in);
      sys_rst_in <= 1'h0;
      t_bus();
      t_stall_grant();
      t_lock();
      t_emu_index();
      t_int();
      wrap_up();
   end
endmodule // cpu_bus_and_interrupt_pins_tb
`default_nettype wire
